/* File: design/cpc_regs.sv */
`timescale 1ns/100ps
module cpc_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Events and levels from the authentication engine and link
  input  wire logic        side_channel_error,
  input  wire logic        downstream_irq_pin,
  input  wire logic        downstream_lock,
  input  wire logic        hot_plug_event,
  input  wire logic        downstream_present,
  input  wire logic        key_ready_set,
  input  wire logic        key_list_ready_set,
  input  wire logic        auth_pass,
  input  wire logic        auth_fail,
  // Controls to the authentication engine and cipher
  output logic             auth_enabled,
  output logic             auth_restart,
  output logic             auth_engine_reset,
  output logic             auth_stall,
  output logic             repeater_mode,
  output logic [1:0]       encrypt_policy,
  output cpc_pkg::cpc_video_type video_mode
);

  logic [7:0] cfg_q;
  logic       auth_en_q, key_ack_q, list_ack_q, enc_on_q, enc_off_q;
  logic       err_q, hpd_q, key_rdy_q, list_rdy_q, link_authenticated_q;
  logic       pulse_restart_q, pulse_reset_q;
  logic       aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wlane_q;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_q && w_q;
  wire wr_cfg  = wr_go && wlane_q && (awaddr_q == cpc_pkg::ADDR_CONFIG);
  wire wr_ctl  = wr_go && wlane_q && (awaddr_q == cpc_pkg::ADDR_CONTROL);
  wire wr_hit  = (awaddr_q == cpc_pkg::ADDR_CONFIG) || (awaddr_q == cpc_pkg::ADDR_CONTROL)
                 || (awaddr_q == cpc_pkg::ADDR_STATUS);
  wire [7:0] wd = wbyte_q;

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_take  = s_axi_arvalid && s_axi_arready;
  wire rd_stat  = rd_take && (s_axi_araddr == cpc_pkg::ADDR_STATUS);
  wire always_enc = (cfg_q[4:3] == cpc_pkg::POL_ALWAYS);
  wire enc_on_rd  = always_enc ? 1'b1 : enc_on_q;
  wire [7:0] ctl_rd = {2'h0, list_ack_q, key_ack_q, 1'b0, enc_on_rd, 1'b0,
                       auth_en_q};
  wire [7:0] sts_rd = {err_q, downstream_irq_pin, downstream_lock, hpd_q,
                       downstream_present, list_rdy_q, key_rdy_q,
                       link_authenticated_q};
  wire [7:0] rd_byte = (s_axi_araddr == cpc_pkg::ADDR_CONFIG)  ? cfg_q :
                       (s_axi_araddr == cpc_pkg::ADDR_CONTROL) ? ctl_rd :
                       (s_axi_araddr == cpc_pkg::ADDR_STATUS)  ? sts_rd : 8'h00;
  wire rd_hit = (s_axi_araddr == cpc_pkg::ADDR_CONFIG) ||
                (s_axi_araddr == cpc_pkg::ADDR_CONTROL) ||
                (s_axi_araddr == cpc_pkg::ADDR_STATUS);

  // Control write decode
  wire set_en    = wr_ctl && wd[cpc_pkg::CTL_ENABLE];
  wire set_dis   = wr_ctl && (wd[cpc_pkg::CTL_DISABLE] || wd[cpc_pkg::CTL_RESET]);
  wire set_kack  = wr_ctl && wd[cpc_pkg::CTL_KEY_ACK];
  wire set_lack  = wr_ctl && wd[cpc_pkg::CTL_LIST_ACK];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cpc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? cpc_pkg::RESP_OKAY : cpc_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? cpc_pkg::RESP_OKAY : cpc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registers and status flags; status sets beat a same-cycle clear, but disable beats enable and key/list ready beats the acks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q <= cpc_pkg::CONFIG_RESET;
      auth_en_q <= 1'b0;
      key_ack_q <= 1'b0;
      list_ack_q <= 1'b0;
      enc_on_q <= 1'b0;
      enc_off_q <= 1'b0;
      err_q <= 1'b0;
      hpd_q <= 1'b0;
      key_rdy_q <= 1'b0;
      list_rdy_q <= 1'b0;
      link_authenticated_q <= 1'b0;
      pulse_restart_q <= 1'b0;
      pulse_reset_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wd;
      end
      if (wr_ctl && !always_enc) begin
        enc_on_q <= wd[cpc_pkg::CTL_ENC_ON];
      end
      enc_off_q <= wr_ctl && wd[cpc_pkg::CTL_ENC_OFF];
      pulse_restart_q <= set_en;
      pulse_reset_q <= wr_ctl && wd[cpc_pkg::CTL_RESET];
      if (set_dis) begin
        auth_en_q <= 1'b0;
      end else if (set_en) begin
        auth_en_q <= 1'b1;
      end
      if (key_ready_set) begin
        key_ack_q <= 1'b0;
      end else if (set_kack) begin
        key_ack_q <= 1'b1;
      end
      if (key_list_ready_set) begin
        list_ack_q <= 1'b0;
      end else if (set_lack) begin
        list_ack_q <= 1'b1;
      end
      err_q <= side_channel_error || (err_q && !rd_stat);
      hpd_q <= hot_plug_event || (hpd_q && !rd_stat);
      list_rdy_q <= key_list_ready_set || (list_rdy_q && !set_lack);
      key_rdy_q <= key_ready_set ||
                   (key_rdy_q && !set_kack && !auth_fail);
      link_authenticated_q <= auth_pass ||
                  (link_authenticated_q && !auth_fail && !set_en && !set_dis);
    end
  end

  assign auth_enabled      = auth_en_q;
  assign auth_restart      = pulse_restart_q;
  assign auth_engine_reset = pulse_reset_q;
  assign repeater_mode     = cfg_q[cpc_pkg::CFG_REPEATER];
  assign encrypt_policy    = cfg_q[4:3];
  // Engine holds while a list or (non-repeater) a key awaits the host
  assign auth_stall = list_rdy_q || (key_rdy_q && !repeater_mode);
  wire enc_req = always_enc || (enc_on_q && !enc_off_q);
  assign video_mode = !enc_req ? cpc_pkg::CPC_VIDEO_CLEAR :
                      link_authenticated_q ? cpc_pkg::CPC_VIDEO_ENCRYPTED :
                      cpc_pkg::CPC_VIDEO_BLUE;
endmodule

/* File: design/cpc_pkg.sv */
package cpc_pkg;
  localparam logic [7:0] ADDR_CONFIG  = 8'hC2;
  localparam logic [7:0] ADDR_CONTROL = 8'hC3;
  localparam logic [7:0] ADDR_STATUS  = 8'hC4;
  localparam int CFG_REPEATER = 5;
  localparam int CFG_POL_LO   = 3;
  localparam int CTL_RESET    = 7;
  localparam int CTL_LIST_ACK = 5;
  localparam int CTL_KEY_ACK  = 4;
  localparam int CTL_ENC_OFF  = 3;
  localparam int CTL_ENC_ON   = 2;
  localparam int CTL_DISABLE  = 1;
  localparam int CTL_ENABLE   = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h80;
  localparam logic [1:0] POL_WHEN_AUTH = 2'h0;
  localparam logic [1:0] POL_REG       = 2'h1;
  localparam logic [1:0] POL_ALWAYS    = 2'h2;
  localparam logic [1:0] POL_INBAND    = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CPC_VIDEO_CLEAR,
    CPC_VIDEO_ENCRYPTED,
    CPC_VIDEO_BLUE
  } cpc_video_type;
endpackage

/* File: dv/cpc_regs_props.sv */
`timescale 1ns/100ps
module cpc_regs_props (
  // Watched ports
  input wire logic        clk_sys, sys_rst, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic        side_channel_error, downstream_irq_pin, downstream_lock,
  input wire logic        hot_plug_event, downstream_present, key_ready_set,
  input wire logic        key_list_ready_set, repeater_mode, auth_stall,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire st_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == cpc_pkg::ADDR_STATUS;
  property p_irq; st_rd |=> s_axi_rdata[6] == $past(downstream_irq_pin); endproperty
  a_irq: assert property (p_irq) else $error("irq status bit wrong");
  property p_lock; st_rd |=> s_axi_rdata[5] == $past(downstream_lock); endproperty
  a_lock: assert property (p_lock) else $error("lock status bit wrong");
  property p_pres; st_rd |=> s_axi_rdata[3] == $past(downstream_present); endproperty
  a_pres: assert property (p_pres) else $error("present status bit wrong");
  property p_err; side_channel_error ##[1:2] st_rd |=> s_axi_rdata[7]; endproperty
  a_err: assert property (p_err) else $error("side error not reported");
  property p_hot; hot_plug_event ##[1:2] st_rd |=> s_axi_rdata[4]; endproperty
  a_hot: assert property (p_hot) else $error("hot plug not reported");
  property p_keep; side_channel_error && st_rd ##[2:3] st_rd |=> s_axi_rdata[7]; endproperty
  a_keep: assert property (p_keep) else $error("error lost on same-cycle read");
  property p_klist; key_list_ready_set |=> auth_stall; endproperty
  a_klist: assert property (p_klist) else $error("no stall on key list");
  property p_key; key_ready_set && !repeater_mode |=> auth_stall; endproperty
  a_key: assert property (p_key) else $error("no stall on key ready");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answer pending");
  c_rd: cover property (st_rd);
  c_key: cover property (key_ready_set && !repeater_mode);
  c_list: cover property (key_list_ready_set);
endmodule
bind cpc_regs cpc_regs_props u_props (.*);

/* File: dv/cpc_regs_tb_top.sv */
`timescale 1ns/100ps
module cpc_regs_tb_top;
  logic clk_sys = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic downstream_irq_pin = 1'b1, downstream_lock = 1'b0, downstream_present = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic auth_enabled, auth_restart, auth_engine_reset, auth_stall, repeater_mode;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rd_v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, encrypt_policy, rsp;
  logic [5:0] ev = 6'h00;
  cpc_pkg::cpc_video_type video_mode;
  wire side_channel_error = ev[0], hot_plug_event = ev[1], key_ready_set = ev[2];
  wire key_list_ready_set = ev[3], auth_pass = ev[4], auth_fail = ev[5];
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // Write address, write data, read address, expected read byte
  logic [31:0] tbl [12] = '{32'hC200C300, 32'hC304C304, 32'hC305C305, 32'hC304C305,
    32'hC30CC305, 32'hC30EC304, 32'hC210C304, 32'hC300C304, 32'hC208C208,
    32'hC218C218, 32'hC300C300, 32'hC4FFC440};
  cpc_regs dut (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One AXI4-Lite write or read; every channel is judged at the rising edge that takes it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = w ? (s_axi_bvalid && s_axi_bready) : (s_axi_rvalid && s_axi_rready);
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd_v = s_axi_rdata[7:0];
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rdata", e, rd_v);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 6'h00;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (tbl[i]) begin
      acc(1'b1, tbl[i][31:24], tbl[i][23:16]);
      rchk(tbl[i][15:8], tbl[i][7:0]);
    end
    $display("test done: register table");
    acc(1'b1, 8'h40, 8'h00);
    chk("bresp", {6'h0, cpc_pkg::RESP_SLVERR}, {6'h0, rsp});
    downstream_irq_pin <= 1'b0;
    downstream_lock <= 1'b1;
    downstream_present <= 1'b1;
    pulse(6'h07);
    rchk(cpc_pkg::ADDR_STATUS, 8'hBA);
    rchk(cpc_pkg::ADDR_STATUS, 8'h2A);
    chk("stall", 8'h01, {7'h0, auth_stall});
    acc(1'b1, cpc_pkg::ADDR_CONTROL, 8'h10);
    rchk(cpc_pkg::ADDR_STATUS, 8'h28);
    rchk(cpc_pkg::ADDR_CONTROL, 8'h10);
    pulse(6'h04);
    rchk(cpc_pkg::ADDR_CONTROL, 8'h00);
    pulse(6'h20);
    rchk(cpc_pkg::ADDR_STATUS, 8'h28);
    pulse(6'h08);
    rchk(cpc_pkg::ADDR_STATUS, 8'h2C);
    acc(1'b1, cpc_pkg::ADDR_CONTROL, 8'h20);
    rchk(cpc_pkg::ADDR_STATUS, 8'h28);
    chk("stall", 8'h00, {7'h0, auth_stall});
    acc(1'b1, cpc_pkg::ADDR_CONFIG, 8'h08);
    acc(1'b1, cpc_pkg::ADDR_CONTROL, 8'h05);
    chk("video", {6'h0, cpc_pkg::CPC_VIDEO_BLUE}, {6'h0, video_mode});
    pulse(6'h10);
    rchk(cpc_pkg::ADDR_STATUS, 8'h29);
    chk("video", {6'h0, cpc_pkg::CPC_VIDEO_ENCRYPTED}, {6'h0, video_mode});
    acc(1'b1, cpc_pkg::ADDR_CONTROL, 8'h05);
    rchk(cpc_pkg::ADDR_STATUS, 8'h28);
    $display("test done: status events");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(cpc_pkg::ADDR_CONFIG, 8'h80);
    rchk(cpc_pkg::ADDR_CONTROL, 8'h00);
    $display("test done: reset");
    finish_test();
  end
endmodule
